// >>> verilog/lci_regs.sv
// Control/status, init-block address and mask/defer register slice.
// Assumes an APB master on pclk; event levels come from the datapath.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Writing start enables transmit, receive, buffers; clears halt.
// - Start with init together runs initialization before normal operation.
// - Start sets only on one written; cleared by reset or halt.
// - Init write of one launches init block fetch and clears halt.
// - Init stays set after the init sequence completes.
// - Init sets only on one written; cleared by reset or halt.
// - Low address write also copies value into low shadow.
// - Address registers accessible only while halted; reset leaves them.
// - High address holds bits 23:16 in 7:0; upper byte zero.
// - High address write also copies value into high shadow.
// - Each set mask bit blocks its event from the summary flag.
// - Mask and defer bits cleared by reset, kept across halt.
// - Mask register bit 4 selects single-part transmit deferral.
// - Mask register bit 3 selects modified back-off; read/write.
// - Auto-pad pads short frames to 64 bytes, check sequence after pad.
// - Auto-pad overrides the per-frame check-sequence disable.
// - Auto-strip removes pad and check sequence from received frames.
// - Transmit poll disable cleared by reset, so polling runs.
// - Halt stops activity until start or init; halt wins when together.
// - Poll disable bit 12 stops automatic transmit descriptor polling.
module lci_regs (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Datapath events and handshakes
   input  wire lci_pkg::lci_events_t events,
   input  wire logic               init_fetch_done,
   input  wire logic               tx_check_seq_disable,
   // Engine controls
   output logic                    tx_enable,
   output logic                    rx_enable,
   output logic                    bm_enable,
   output logic                    halted,
   output logic                    init_fetch_req,
   output logic [23:0]             init_block_address,
   output lci_pkg::lci_cfg_t       cfg,
   output logic                    tx_fcs_append,
   output logic [6:0]              tx_pad_min_bytes,
   output logic                    summary_irq_flag
);

   // ==========================================================
   // State
   typedef struct packed {
      logic        halt;
      logic        start_cmd;
      logic        init_cmd;
      logic        init_busy;
      logic        run;
      logic [15:0] mask_defer;
      logic [15:0] feat;
      logic        irq;
      logic        fcs_append;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } lci_state_t;

   typedef struct packed {
      logic [15:0] addr_low;
      logic [7:0]  addr_high;
      logic [15:0] shadow_low;
      logic [7:0]  shadow_high;
   } lci_addr_t;

   lci_state_t st_ff;
   lci_state_t nxt_st;
   lci_addr_t  ad_ff;
   lci_addr_t  nxt_ad;

   logic        acc_wr;
   logic        setup;
   logic        mapped;
   logic [15:0] wd;
   logic [5:0]  raw_ev;
   logic [5:0]  ev_mask;

   assign setup  = psel && !penable;
   assign acc_wr = psel && penable && st_ff.pready && pwrite;
   assign wd     = pwdata[15:0];
   assign raw_ev = {events.babble, events.missed, events.mem_error,
                    events.rx_done, events.tx_done, events.init_done};
   assign ev_mask = {st_ff.mask_defer[lci_pkg::BIT_BABBLE_M],
                     st_ff.mask_defer[lci_pkg::BIT_MISSED_M],
                     st_ff.mask_defer[lci_pkg::BIT_MEMERR_M],
                     st_ff.mask_defer[lci_pkg::BIT_RXDONE_M],
                     st_ff.mask_defer[lci_pkg::BIT_TXDONE_M],
                     st_ff.mask_defer[lci_pkg::BIT_IDONE_M]};

   always_comb begin
      unique case (paddr)
         lci_pkg::OFS_CTRL_STATUS,
         lci_pkg::OFS_IADDR_LOW,
         lci_pkg::OFS_IADDR_HIGH,
         lci_pkg::OFS_MASK_DEFER,
         lci_pkg::OFS_TEST_FEAT,
         lci_pkg::OFS_SHADOW_LOW,
         lci_pkg::OFS_SHADOW_HIGH: mapped = 1'b1;
         default:                  mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_ad = ad_ff;
      // No wait states: answer prepared in setup, shown in access
      nxt_st.pready  = setup;
      nxt_st.pslverr = setup && !mapped;
      nxt_st.prdata  = 32'h0000_0000;
      if (setup && !pwrite) begin
         unique case (paddr)
            lci_pkg::OFS_CTRL_STATUS: begin
               nxt_st.prdata[lci_pkg::BIT_INIT]    = st_ff.init_cmd;
               nxt_st.prdata[lci_pkg::BIT_START]   = st_ff.start_cmd;
               nxt_st.prdata[lci_pkg::BIT_HALT]    = st_ff.halt;
               nxt_st.prdata[lci_pkg::BIT_RUN]     = st_ff.run;
               nxt_st.prdata[lci_pkg::BIT_IBUSY]   = st_ff.init_busy;
               nxt_st.prdata[lci_pkg::BIT_SUMMARY] = st_ff.irq;
            end
            lci_pkg::OFS_IADDR_LOW: begin
               if (st_ff.halt) begin
                  nxt_st.prdata[15:0] = ad_ff.addr_low;
               end
            end
            lci_pkg::OFS_IADDR_HIGH: begin
               if (st_ff.halt) begin
                  nxt_st.prdata[7:0] = ad_ff.addr_high;
               end
            end
            lci_pkg::OFS_MASK_DEFER: begin
               nxt_st.prdata[15:0] = st_ff.mask_defer;
            end
            lci_pkg::OFS_TEST_FEAT: begin
               nxt_st.prdata[15:0] = st_ff.feat;
            end
            lci_pkg::OFS_SHADOW_LOW: begin
               nxt_st.prdata[15:0] = ad_ff.shadow_low;
            end
            lci_pkg::OFS_SHADOW_HIGH: begin
               nxt_st.prdata[7:0] = ad_ff.shadow_high;
            end
            default: begin
               nxt_st.prdata = 32'h0000_0000;
            end
         endcase
      end
      // Init fetch finishes; init command stays set
      if (st_ff.init_busy && init_fetch_done) begin
         nxt_st.init_busy = 1'b0;
      end
      if (acc_wr) begin
         unique case (paddr)
            lci_pkg::OFS_CTRL_STATUS: begin
               if (wd[lci_pkg::BIT_HALT]) begin
                  nxt_st.halt      = 1'b1;
                  nxt_st.start_cmd = 1'b0;
                  nxt_st.init_cmd  = 1'b0;
                  nxt_st.init_busy = 1'b0;
               end else begin
                  if (wd[lci_pkg::BIT_START]) begin
                     nxt_st.start_cmd = 1'b1;
                     nxt_st.halt      = 1'b0;
                  end
                  if (wd[lci_pkg::BIT_INIT]) begin
                     nxt_st.init_cmd  = 1'b1;
                     nxt_st.init_busy = 1'b1;
                     nxt_st.halt      = 1'b0;
                  end
               end
            end
            lci_pkg::OFS_IADDR_LOW: begin
               if (st_ff.halt) begin
                  nxt_ad.addr_low   = wd;
                  nxt_ad.shadow_low = wd;
               end
            end
            lci_pkg::OFS_IADDR_HIGH: begin
               if (st_ff.halt) begin
                  nxt_ad.addr_high = wd[7:0] & lci_pkg::IADDR_HIGH_MSK;
                  nxt_ad.shadow_high = wd[7:0];
               end
            end
            lci_pkg::OFS_MASK_DEFER: begin
               nxt_st.mask_defer = wd & lci_pkg::MASK_DEFER_WMASK;
            end
            lci_pkg::OFS_TEST_FEAT: begin
               nxt_st.feat = wd & lci_pkg::FEAT_WMASK;
            end
            default: begin
               nxt_st.feat = st_ff.feat;
            end
         endcase
      end
      // Run only once started and no init fetch pending
      nxt_st.run = nxt_st.start_cmd && !nxt_st.init_busy;
      nxt_st.irq = |(raw_ev & ~ev_mask);
      nxt_st.fcs_append = st_ff.feat[lci_pkg::BIT_AUTO_PAD] ||
                          !tx_check_seq_disable;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff            <= '0;
         st_ff.halt       <= 1'b1;
         st_ff.mask_defer <= lci_pkg::MASK_DEFER_RST;
         st_ff.feat       <= lci_pkg::FEAT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Address registers keep their contents through reset
   always_ff @(posedge pclk) begin
      ad_ff <= nxt_ad;
   end

   // ==========================================================
   // Outputs
   assign prdata             = st_ff.prdata;
   assign pready             = st_ff.pready;
   assign pslverr            = st_ff.pslverr;
   assign halted             = st_ff.halt;
   assign tx_enable          = st_ff.run;
   assign rx_enable          = st_ff.run;
   assign bm_enable          = st_ff.run;
   assign init_fetch_req     = st_ff.init_busy;
   assign init_block_address = {ad_ff.shadow_high, ad_ff.shadow_low};
   assign summary_irq_flag   = st_ff.irq;
   assign tx_fcs_append      = st_ff.fcs_append;
   assign tx_pad_min_bytes   = lci_pkg::PAD_MIN_BYTES;
   assign cfg = {st_ff.mask_defer[lci_pkg::BIT_TWO_PART],
                 st_ff.mask_defer[lci_pkg::BIT_BACKOFF],
                 st_ff.feat[lci_pkg::BIT_AUTO_PAD],
                 st_ff.feat[lci_pkg::BIT_STRIP],
                 st_ff.feat[lci_pkg::BIT_POLL_DIS]};

   // ==========================================================
   // Assertions
   a_halt_clears_run: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_wr && paddr == lci_pkg::OFS_CTRL_STATUS && wd[lci_pkg::BIT_HALT]
      |=> halted && !tx_enable && !st_ff.start_cmd && !st_ff.init_cmd)
      else $error("halt write did not stop the block");

   a_start_runs: assert property (@(posedge pclk) disable iff (!presetn)
      acc_wr && paddr == lci_pkg::OFS_CTRL_STATUS && wd[lci_pkg::BIT_START]
      && !wd[lci_pkg::BIT_HALT] && !wd[lci_pkg::BIT_INIT] && !init_fetch_req
      |=> tx_enable && rx_enable && bm_enable && !halted)
      else $error("start write did not enable the engines");

   a_init_first: assert property (@(posedge pclk) disable iff (!presetn)
      init_fetch_req |-> !tx_enable)
      else $error("engines ran during init fetch");

   a_start_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.start_cmd && !(acc_wr && paddr == lci_pkg::OFS_CTRL_STATUS)
      |=> st_ff.start_cmd)
      else $error("start command dropped without halt");

   a_init_launch: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_wr && paddr == lci_pkg::OFS_CTRL_STATUS && wd[lci_pkg::BIT_INIT]
      && !wd[lci_pkg::BIT_HALT] |=> init_fetch_req && !halted)
      else $error("init write did not launch fetch");

   a_init_stays: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.init_cmd && init_fetch_req && init_fetch_done && !acc_wr
      |=> st_ff.init_cmd && !init_fetch_req)
      else $error("init command cleared at completion");

   a_shadow_copy: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_wr && paddr == lci_pkg::OFS_IADDR_LOW && halted
      |=> init_block_address[15:0] == $past(wd))
      else $error("low shadow not updated");

   a_addr_locked: assert property (
      @(posedge pclk) disable iff (!presetn)
      !halted |=> $stable(init_block_address))
      else $error("address changed while running");

   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      ((raw_ev & ~ev_mask) == 6'h00) |=> !summary_irq_flag)
      else $error("masked event raised summary flag");

   a_fcs_override: assert property (
      @(posedge pclk) disable iff (!presetn)
      cfg.tx_auto_pad && $past(cfg.tx_auto_pad) |-> tx_fcs_append)
      else $error("auto-pad did not force check sequence");

   c_start_init: cover property (@(posedge pclk) disable iff (!presetn)
      init_fetch_req && st_ff.start_cmd ##[1:50] tx_enable);
   c_halt_run: cover property (@(posedge pclk) disable iff (!presetn)
      tx_enable ##[1:50] halted);
   c_irq_flag: cover property (@(posedge pclk) disable iff (!presetn)
      summary_irq_flag);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);

endmodule : lci_regs

`default_nettype wire

// >>> verilog/lci_pkg.sv
// Package for the control, init-address and mask register slice.
// Assumes an APB master with 32-bit data and a single core clock.
package lci_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_IADDR_LOW   = 8'h04;
   localparam logic [7:0] OFS_IADDR_HIGH  = 8'h08;
   localparam logic [7:0] OFS_MASK_DEFER  = 8'h0C;
   localparam logic [7:0] OFS_TEST_FEAT   = 8'h10;
   localparam logic [7:0] OFS_SHADOW_LOW  = 8'h40;
   localparam logic [7:0] OFS_SHADOW_HIGH = 8'h44;

   // ==========================================================
   // Control/status field positions
   localparam int BIT_INIT    = 0;
   localparam int BIT_START   = 1;
   localparam int BIT_HALT    = 2;
   localparam int BIT_RUN     = 4;
   localparam int BIT_IBUSY   = 5;
   localparam int BIT_SUMMARY = 7;

   // ==========================================================
   // Mask/defer field positions
   localparam int BIT_BABBLE_M = 14;
   localparam int BIT_MISSED_M = 12;
   localparam int BIT_MEMERR_M = 11;
   localparam int BIT_RXDONE_M = 10;
   localparam int BIT_TXDONE_M = 9;
   localparam int BIT_IDONE_M  = 8;
   localparam int BIT_TWO_PART = 4;
   localparam int BIT_BACKOFF  = 3;
   localparam logic [15:0] MASK_DEFER_WMASK = 16'h5F18;

   // ==========================================================
   // Test/features field positions
   localparam int BIT_POLL_DIS = 12;
   localparam int BIT_AUTO_PAD = 11;
   localparam int BIT_STRIP    = 10;
   localparam logic [15:0] FEAT_WMASK = 16'h1C00;

   // ==========================================================
   // Reset values and constants
   localparam logic [15:0] MASK_DEFER_RST = 16'h0000;
   localparam logic [15:0] FEAT_RST       = 16'h0000;
   localparam logic [7:0]  IADDR_HIGH_MSK = 8'hFF;
   localparam logic [6:0]  PAD_MIN_BYTES  = 7'h40;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic babble;
      logic missed;
      logic mem_error;
      logic rx_done;
      logic tx_done;
      logic init_done;
   } lci_events_t;

   typedef struct packed {
      logic two_part_defer_disable;
      logic modified_backoff_enable;
      logic tx_auto_pad;
      logic rx_auto_strip;
      logic tx_poll_disable;
   } lci_cfg_t;

endpackage : lci_pkg

// >>> tb/testbench.sv
// Self-checking bench for the control, init-address and mask slice.
// Assumes lci_pkg and lci_regs compiled first; APB driven from here.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // ==========================================================
   // Signals
   logic                 pclk, presetn, psel, penable, pwrite;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata;
   logic                 pready, pslverr;
   lci_pkg::lci_events_t events;
   logic                 init_fetch_done, tx_check_seq_disable;
   logic                 tx_enable, rx_enable, bm_enable, halted;
   logic                 init_fetch_req, tx_fcs_append, summary_irq_flag;
   logic [23:0]          init_block_address;
   lci_pkg::lci_cfg_t    cfg;
   logic [6:0]           tx_pad_min_bytes;
   int                   error_cnt, checks_done, cyc;
   logic [31:0]          rd_val;
   logic                 rd_err;
   int                   mb [6] = '{14, 12, 11, 10, 9, 8};

   lci_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .events(events), .init_fetch_done(init_fetch_done),
      .tx_check_seq_disable(tx_check_seq_disable), .tx_enable(tx_enable),
      .rx_enable(rx_enable), .bm_enable(bm_enable), .halted(halted),
      .init_fetch_req(init_fetch_req),
      .init_block_address(init_block_address), .cfg(cfg),
      .tx_fcs_append(tx_fcs_append), .tx_pad_min_bytes(tx_pad_min_bytes),
      .summary_irq_flag(summary_irq_flag));

   // ==========================================================
   // Clock and timeout
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         end_of_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         error_cnt = error_cnt + 1;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_val = prdata;
      rd_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd_val, exp);
   endtask : rd

   task automatic pause();
      repeat (3) @(negedge pclk);
   endtask : pause

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic fetch_done();
      @(posedge pclk);
      init_fetch_done <= 1'b1;
      @(posedge pclk);
      init_fetch_done <= 1'b0;
      pause();
   endtask : fetch_done

   // ==========================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, init_fetch_done} = 4'h0;
      {paddr, pwdata, events} = '0;
      tx_check_seq_disable = 1'b0;
      presetn = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      cyc = 0;
      do_reset();
      rd(8'h00, 32'h0000_0004);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      pause();
      chk({27'h0, cfg}, 32'h0000_0000);
      chk({25'h0, tx_pad_min_bytes}, 32'h0000_0040);
      // Init address while halted
      wr(8'h04, 32'h0000_1234);
      wr(8'h08, 32'h0000_00AB);
      rd(8'h04, 32'h0000_1234);
      rd(8'h40, 32'h0000_1234);
      rd(8'h08, 32'h0000_00AB);
      rd(8'h44, 32'h0000_00AB);
      chk({8'h0, init_block_address}, 32'h00AB_1234);
      // Masks and deferral
      wr(8'h0C, 32'h0000_5F18);
      rd(8'h0C, 32'h0000_5F18);
      pause();
      chk({27'h0, cfg}, 32'h0000_0018);
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         events <= 6'h20 >> i;
         wr(8'h0C, 32'h0000_5F18);
         pause();
         chk({31'h0, summary_irq_flag}, 32'h0000_0000);
         wr(8'h0C, 32'h0000_5F18 & ~(32'h1 << mb[i]));
         pause();
         chk({31'h0, summary_irq_flag}, 32'h0000_0001);
         rd(8'h00, 32'h0000_0084);
      end
      @(posedge pclk);
      events <= '0;
      wr(8'h0C, 32'h0000_5F18);
      // Test and features
      tx_check_seq_disable <= 1'b1;
      wr(8'h10, 32'h0000_1C00);
      rd(8'h10, 32'h0000_1C00);
      pause();
      chk({27'h0, cfg}, 32'h0000_001F);
      chk({31'h0, tx_fcs_append}, 32'h0000_0001);
      wr(8'h10, 32'h0000_0000);
      pause();
      chk({31'h0, tx_fcs_append}, 32'h0000_0000);
      @(posedge pclk);
      tx_check_seq_disable <= 1'b0;
      pause();
      chk({31'h0, tx_fcs_append}, 32'h0000_0001);
      // Start alone
      wr(8'h00, 32'h0000_0002);
      pause();
      chk({28'h0, tx_enable, rx_enable, bm_enable, halted}, 32'hE);
      rd(8'h00, 32'h0000_0012);
      wr(8'h00, 32'h0000_0000);
      rd(8'h00, 32'h0000_0012);
      wr(8'h04, 32'h0000_5678);
      rd(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_0004);
      pause();
      chk({28'h0, tx_enable, rx_enable, bm_enable, halted}, 32'h1);
      rd(8'h00, 32'h0000_0004);
      rd(8'h0C, 32'h0000_5F18);
      rd(8'h04, 32'h0000_1234);
      // Start with init together
      wr(8'h00, 32'h0000_0003);
      pause();
      chk({30'h0, init_fetch_req, tx_enable}, 32'h0000_0002);
      rd(8'h00, 32'h0000_0023);
      fetch_done();
      chk({30'h0, init_fetch_req, tx_enable}, 32'h0000_0001);
      rd(8'h00, 32'h0000_0013);
      // Halt wins, then init alone
      wr(8'h00, 32'h0000_0007);
      rd(8'h00, 32'h0000_0004);
      wr(8'h00, 32'h0000_0001);
      pause();
      chk({30'h0, init_fetch_req, halted}, 32'h0000_0002);
      fetch_done();
      chk({31'h0, tx_enable}, 32'h0000_0000);
      rd(8'h00, 32'h0000_0001);
      // Unmapped address
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, rd_err}, 32'h0000_0001);
      chk(rd_val, 32'h0000_0000);
      // Second reset keeps the address
      do_reset();
      rd(8'h04, 32'h0000_1234);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h00, 32'h0000_0004);
      end_of_test();
   end
endmodule : testbench

`default_nettype wire
